/* File: hw/gpfm_pin_function_mux.sv */
// Purpose: Pin function logic with APB registers and edge interrupt
// Assumes: pclk 10 MHz, presetn asynchronous active low
// Notes:   Zero-wait APB slave; routed clocks leave combinationally
`timescale 1ns/10ps
`include "gpfm_cfg.svh"

// Overview of operation
// R01 - Two output pins and seven two-way pins drive low, high or float.
// R02 - Each pin takes its function from a three-bit select field.
// R03 - A floating two-way pin reads back its live level in the state register.
// R04 - Each two-way pin has a latched bit set by the selected edge.
// R05 - Pins four to seven work only in narrow parallel interface modes.
// R06 - Codes 000, 001, 010 float, drive low, drive high.
// R07 - Code 011 on group A gives active-low interrupt; two-way pins open-drain.
// R08 - Code 100 routes the reference PLL clock.
// R09 - Code 101 on group A routes unsquelched recovered clock at chosen rate.
// R10 - Code 110 on group A routes live link status.
// R11 - Code 111 on group A routes event generator one.
// R12 - Code 011 on other pins routes the time engine clock.
// R13 - Code 101 on other pins routes recovered clock, squelch applied.
// R14 - Code 110 on output B and pin two routes carrier sense.
// R15 - Code 111 on output B and pin two routes event generator two.
// R16 - Codes 110 and 111 on pins four to seven route events one, two.
// R17 - Squelch holds clock low on any loss flag or latched link down.
// R18 - Squelch lasts until every latched loss flag has cleared.
// R19 - Pin inputs are synchronised before live state and edge detection.
module gpfm_pin_function_mux (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Output-only pins
  output logic             aux_out_a_o,
  output logic             aux_out_a_oe,
  output logic             aux_out_b_o,
  output logic             aux_out_b_oe,
  // Two-way pins, bit k is gen_pin_(k+1)
  input  wire logic [6:0]  gen_pin_i,
  output logic      [6:0]  gen_pin_o,
  output logic      [6:0]  gen_pin_oe,
  // Routed sources
  input  wire logic        ref_pll_clk_125,
  input  wire logic        recovered_clk_25,
  input  wire logic        recovered_clk_125,
  input  wire logic        link_up,
  input  wire logic        carrier_sense,
  input  wire logic        time_engine_clock_out,
  input  wire logic        event_gen_out_1,
  input  wire logic        event_gen_out_2,
  // Latched squelch flags
  input  wire logic        analog_signal_loss_flag,
  input  wire logic        cdr_signal_loss_flag,
  input  wire logic        cdr_lock_loss_flag,
  input  wire logic        link_state_latched,
  // Parallel interface in MII or RGMII
  input  wire logic        narrow_mii_mode,
  // Interrupt
  output logic             irq
);
  import gpfm_pkg::*;

  // ==========================================
  // Declarations
  gpfm_core_t st_reg;
  gpfm_core_t st_next;
  logic        access;
  logic        wr;
  logic        rd;
  logic        setup_rd;
  logic [6:0]  usable;
  logic [6:0]  live_vis;
  logic [6:0]  hits;
  logic        warm_ok;
  logic [31:0] rdata;
  gpfm_edge_t  edge_lo;
  gpfm_edge_t  edge_hi;

  gpfm_io_if io (
    .pclk    (pclk),
    .presetn (presetn)
  );

  // ==========================================
  // Functions
  function automatic logic mapped(input logic [11:0] a);
    case (a)
      `GPFM_OFF_CFG_A, `GPFM_OFF_CFG_B, `GPFM_OFF_STATE,
      `GPFM_OFF_CTRL, `GPFM_OFF_ISTAT, `GPFM_OFF_IMASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  function automatic logic edge_hit(input gpfm_edge_t es, input logic cur, input logic prv);
    case (es)
      GPFM_EDGE_RISE: edge_hit = cur & ~prv;
      GPFM_EDGE_FALL: edge_hit = ~cur & prv;
      GPFM_EDGE_BOTH: edge_hit = cur ^ prv;
      default:        edge_hit = 1'b0;
    endcase
  endfunction

  // ==========================================
  // Submodules
  gpfm_pin_sync u_sync (
    .io (io.sync)
  );

  gpfm_pin_mux u_mux (
    .io (io.mux)
  );

  // ==========================================
  // Carrier hookup
  always_comb begin
    for (int i = 0; i < `GPFM_CFGA_PINS; i++) begin
      io.sel[i] = gpfm_sel_t'(st_reg.cfg_a[`GPFM_SEL_W*i +: `GPFM_SEL_W]); // [R02]
    end
    for (int i = 0; i < 4; i++) begin
      io.sel[i+5] = gpfm_sel_t'(st_reg.cfg_b[`GPFM_SEL_W*i +: `GPFM_SEL_W]); // [R02]
    end
  end

  assign io.freq_sel   = st_reg.ctrl[`GPFM_FREQ];
  assign io.squelch_en = st_reg.ctrl[`GPFM_SQL];
  assign io.irq        = irq;
  assign io.narrow     = narrow_mii_mode;
  assign io.ref_clk    = ref_pll_clk_125;
  assign io.rec25      = recovered_clk_25;
  assign io.rec125     = recovered_clk_125;
  assign io.link_up    = link_up;
  assign io.crs        = carrier_sense;
  assign io.te_clk     = time_engine_clock_out;
  assign io.ev1        = event_gen_out_1;
  assign io.ev2        = event_gen_out_2;
  assign io.alos       = analog_signal_loss_flag;
  assign io.rlos       = cdr_signal_loss_flag;
  assign io.rlol       = cdr_lock_loss_flag;
  assign io.link_lat   = link_state_latched;
  assign io.raw_in     = gen_pin_i;

  // ==========================================
  // Pin outputs
  assign aux_out_a_o  = io.pin_out[0];
  assign aux_out_a_oe = io.pin_oe[0];
  assign aux_out_b_o  = io.pin_out[1];
  assign aux_out_b_oe = io.pin_oe[1];
  assign gen_pin_o    = io.pin_out[8:2];
  assign gen_pin_oe   = io.pin_oe[8:2];

  // ==========================================
  // Bus decode
  assign access   = psel & penable;
  assign wr       = access & pwrite;
  assign rd       = access & ~pwrite;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign pslverr  = access & ~mapped(paddr);
  assign prdata   = st_reg.prdata;

  // ==========================================
  // Input state and edges
  assign usable   = {{4{narrow_mii_mode}}, 3'h7}; // [R05]
  assign live_vis = io.live_in & usable; // [R03] [R19]
  assign edge_lo  = gpfm_edge_t'(st_reg.cfg_b[`GPFM_EDGE_LO +: 2]);
  assign edge_hi  = gpfm_edge_t'(st_reg.cfg_b[`GPFM_EDGE_HI +: 2]);
  // Synchroniser starts at 0 while pins idle high; that first step is no edge
  assign warm_ok  = (st_reg.warm == `GPFM_WARM_EDGES);

  always_comb begin
    for (int i = 0; i < 7; i++) begin
      hits[i] = warm_ok & edge_hit((i < 3) ? edge_lo : edge_hi, live_vis[i], st_reg.prev[i]); // [R04]
    end
  end

  // ==========================================
  // Read mux
  always_comb begin
    rdata = 32'h0000_0000;
    case (paddr)
      `GPFM_OFF_CFG_A: rdata[14:0] = st_reg.cfg_a;
      `GPFM_OFF_CFG_B: rdata[15:0] = st_reg.cfg_b;
      `GPFM_OFF_STATE: begin
        rdata[6:0]                = live_vis; // [R03]
        rdata[`GPFM_LATCH +: 7]   = st_reg.latch; // [R04]
      end
      `GPFM_OFF_CTRL:  rdata[1:0]  = st_reg.ctrl;
      `GPFM_OFF_ISTAT: rdata[6:0]  = st_reg.istat;
      `GPFM_OFF_IMASK: rdata[6:0]  = st_reg.imask;
      default:         rdata       = 32'h0000_0000;
    endcase
  end

  // ==========================================
  // Next state
  always_comb begin
    st_next      = st_reg;
    st_next.prev = live_vis;
    if (!warm_ok) begin
      st_next.warm = st_reg.warm + 3'h1;
    end
    if (setup_rd) begin
      st_next.prdata = rdata;
    end
    // Only bits already reported are cleared; new edges win
    if (rd && paddr == `GPFM_OFF_STATE) begin
      st_next.latch = st_reg.latch & ~st_reg.prdata[`GPFM_LATCH +: 7];
    end
    if (rd && paddr == `GPFM_OFF_ISTAT) begin
      st_next.istat = st_reg.istat & ~st_reg.prdata[6:0];
    end
    st_next.latch = st_next.latch | hits; // [R04]
    st_next.istat = st_next.istat | hits;
    if (wr) begin
      case (paddr)
        `GPFM_OFF_CFG_A: st_next.cfg_a = pwdata[14:0]; // [R02]
        `GPFM_OFF_CFG_B: st_next.cfg_b = pwdata[15:0]; // [R02]
        `GPFM_OFF_CTRL:  st_next.ctrl  = pwdata[1:0];
        `GPFM_OFF_IMASK: st_next.imask = pwdata[6:0];
        default:         st_next.ctrl  = st_next.ctrl;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg        <= '0;
      st_reg.cfg_a  <= `GPFM_RST_CFG_A;
      st_reg.cfg_b  <= `GPFM_RST_CFG_B;
      st_reg.ctrl   <= `GPFM_RST_CTRL;
      st_reg.imask  <= `GPFM_RST_IMASK;
    end else begin
      st_reg <= st_next;
    end
  end

  assign irq = |(st_reg.istat & st_reg.imask);

  // ==========================================
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_cfg_write: assert property ( // [R02]
    wr && paddr == `GPFM_OFF_CFG_A |=> st_reg.cfg_a == $past(pwdata[14:0]))
    else $error("select register not written");

  a_live_level: assert property ( // [R03]
    (narrow_mii_mode && gen_pin_i == $past(gen_pin_i))[*6] |-> live_vis == gen_pin_i)
    else $error("live state does not follow steady pin");

  a_rise_latch: assert property ( // [R04]
    warm_ok && edge_lo == GPFM_EDGE_RISE && live_vis[0] && !st_reg.prev[0] |=> st_reg.latch[0] ##1 st_reg.latch[0])
    else $error("rising edge not latched");

  a_read_clear: assert property ( // [R04]
    rd && paddr == `GPFM_OFF_STATE && st_reg.prdata[`GPFM_LATCH] && !hits[0] |=> !st_reg.latch[0])
    else $error("latched bit not cleared by read");

  a_set_wins: assert property ( // [R04]
    rd && paddr == `GPFM_OFF_ISTAT && hits[1] |=> st_reg.istat[1])
    else $error("edge lost at status read");

  a_irq_raise: assert property ( // [R07]
    hits[2] && st_reg.imask[2] |=> irq [*2])
    else $error("masked-in edge gave no interrupt");

  a_irq_pin: assert property ( // [R07]
    io.sel[0] == GPFM_SEL_ALT3 |-> aux_out_a_oe && aux_out_a_o == !irq)
    else $error("interrupt output level wrong");

  a_unmapped_err: assert property (
    access && !mapped(paddr) |-> pslverr && pready)
    else $error("unmapped address not refused");

  a_link_route: assert property ( // [R10]
    io.sel[2] == GPFM_SEL_ALT6 |-> gen_pin_oe[0] && gen_pin_o[0] == link_up)
    else $error("link status not routed");

  a_free_clock: assert property ( // [R09]
    io.sel[4] == GPFM_SEL_REC && st_reg.ctrl[`GPFM_FREQ] |-> gen_pin_o[2] == recovered_clk_125)
    else $error("group A recovered clock squelched or wrong rate");

  a_warm_quiet: assert property ( // [R04] [R19]
    !warm_ok && !rd |=> $stable(st_reg.latch))
    else $error("edge latched before synchroniser settled");

  a_ref_route: assert property ( // [R08]
    io.sel[1] == GPFM_SEL_REF |-> aux_out_b_oe && aux_out_b_o == ref_pll_clk_125)
    else $error("reference clock not routed");

  a_time_clock: assert property ( // [R12]
    io.sel[3] == GPFM_SEL_ALT3 |-> gen_pin_oe[1] && gen_pin_o[1] == time_engine_clock_out)
    else $error("time engine clock not routed");

  a_sel_low: assert property ( // [R06]
    io.sel[0] == GPFM_SEL_LOW |-> aux_out_a_oe && !aux_out_a_o)
    else $error("drive low select wrong");

  a_squelch_hold: assert property ( // [R17]
    io.sel[3] == GPFM_SEL_REC && st_reg.ctrl[`GPFM_SQL] && analog_signal_loss_flag |-> !gen_pin_o[1])
    else $error("recovered clock not held low");

  a_state_narrow: assert property ( // [R05]
    setup_rd && paddr == `GPFM_OFF_STATE && !narrow_mii_mode |=> prdata[6:3] == 4'h0)
    else $error("unusable pin state visible");

  a_latch_hold: assert property ( // [R04]
    st_reg.latch[3] && !(rd && paddr == `GPFM_OFF_STATE) |=> st_reg.latch[3])
    else $error("latched bit lost without read");

  a_carrier_route: assert property ( // [R14]
    io.sel[1] == GPFM_SEL_ALT6 |-> aux_out_b_oe && aux_out_b_o == carrier_sense)
    else $error("carrier sense not routed");

  a_event_two: assert property ( // [R15]
    io.sel[3] == GPFM_SEL_ALT7 |-> gen_pin_oe[1] && gen_pin_o[1] == event_gen_out_2)
    else $error("event two not routed");
endmodule

/* File: common/gpfm_cfg.svh */
// Purpose: Register offsets, field positions and reset values
// Assumes: 32-bit APB words, one register per aligned word
// Notes:   Included by bare name
`ifndef GPFM_CFG_SVH
`define GPFM_CFG_SVH
// ==========================================
// Register offsets
`define GPFM_OFF_CFG_A 12'h000
`define GPFM_OFF_CFG_B 12'h004
`define GPFM_OFF_STATE 12'h008
`define GPFM_OFF_CTRL  12'h00C
`define GPFM_OFF_ISTAT 12'h010
`define GPFM_OFF_IMASK 12'h014
// ==========================================
// Field positions
`define GPFM_SEL_W     3
`define GPFM_CFGA_PINS 5
`define GPFM_EDGE_LO   12
`define GPFM_EDGE_HI   14
`define GPFM_LATCH     8
`define GPFM_FREQ      0
`define GPFM_SQL       1
// ==========================================
// Reset values
`define GPFM_RST_CFG_A 15'h0000
`define GPFM_RST_CFG_B 16'h0000
`define GPFM_RST_CTRL  2'h0
`define GPFM_RST_IMASK 7'h00
// ==========================================
// Timing counts
`define GPFM_WARM_EDGES 3'h5
`endif

/* File: common/gpfm_pkg.sv */
// Purpose: Shared types of the pin function block
// Assumes: Nothing beyond the cfg header
// Notes:   Pin index 0 aux_out_a, 1 aux_out_b, 2..8 gen_pin_1..7
package gpfm_pkg;
  typedef enum logic [2:0] {
    GPFM_SEL_HIZ  = 3'h0,
    GPFM_SEL_LOW  = 3'h1,
    GPFM_SEL_HIGH = 3'h2,
    GPFM_SEL_ALT3 = 3'h3,
    GPFM_SEL_REF  = 3'h4,
    GPFM_SEL_REC  = 3'h5,
    GPFM_SEL_ALT6 = 3'h6,
    GPFM_SEL_ALT7 = 3'h7
  } gpfm_sel_t;
  typedef enum logic [1:0] {
    GPFM_EDGE_NONE = 2'h0,
    GPFM_EDGE_RISE = 2'h1,
    GPFM_EDGE_FALL = 2'h2,
    GPFM_EDGE_BOTH = 2'h3
  } gpfm_edge_t;
  typedef struct packed {
    logic [14:0] cfg_a;
    logic [15:0] cfg_b;
    logic [1:0]  ctrl;
    logic [6:0]  prev;
    logic [6:0]  latch;
    logic [6:0]  istat;
    logic [6:0]  imask;
    logic [2:0]  warm;
    logic [31:0] prdata;
  } gpfm_core_t;
  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
    logic [6:0] s3;
    logic [6:0] stable;
  } gpfm_sync_t;
endpackage

/* File: common/gpfm_io_if.sv */
// Purpose: Carrier between the core, the pin mux and the synchroniser
// Assumes: One clock domain
// Notes:   sel index follows pin index of the package
`timescale 1ns/10ps
interface gpfm_io_if (
  input wire logic pclk,
  input wire logic presetn
);
  gpfm_pkg::gpfm_sel_t [8:0] sel;
  logic       freq_sel;
  logic       squelch_en;
  logic       irq;
  logic       narrow;
  logic       ref_clk;
  logic       rec25;
  logic       rec125;
  logic       link_up;
  logic       crs;
  logic       te_clk;
  logic       ev1;
  logic       ev2;
  logic       alos;
  logic       rlos;
  logic       rlol;
  logic       link_lat;
  logic [8:0] pin_out;
  logic [8:0] pin_oe;
  logic [6:0] raw_in;
  logic [6:0] live_in;
  modport core (input pclk, presetn, pin_out, pin_oe, live_in,
                output sel, freq_sel, squelch_en, irq, narrow, ref_clk, rec25, rec125,
                link_up, crs, te_clk, ev1, ev2, alos, rlos, rlol, link_lat, raw_in);
  modport mux  (input pclk, presetn, sel, freq_sel, squelch_en, irq, narrow, ref_clk, rec25,
                rec125, link_up, crs, te_clk, ev1, ev2, alos, rlos, rlol, link_lat,
                output pin_out, pin_oe);
  modport sync (input pclk, presetn, raw_in, output live_in);
endinterface

/* File: hw/gpfm_pin_sync.sv */
// Purpose: Three-stage synchroniser for the seven pin inputs
// Assumes: Pins are asynchronous to pclk
// Notes:   A change counts once stages two and three agree
`timescale 1ns/10ps
module gpfm_pin_sync (
  gpfm_io_if.sync io
);
  import gpfm_pkg::*;
  gpfm_sync_t st_reg;
  gpfm_sync_t st_next;

  always_comb begin
    st_next        = st_reg;
    st_next.s1     = io.raw_in;
    st_next.s2     = st_reg.s1;
    st_next.s3     = st_reg.s2;
    st_next.stable = ((st_reg.s2 ~^ st_reg.s3) & st_reg.s3)
                   | ((st_reg.s2 ^ st_reg.s3) & st_reg.stable); // [R19]
  end

  always_ff @(posedge io.pclk or negedge io.presetn) begin
    if (!io.presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign io.live_in = st_reg.stable;

  a_sync_agree: assert property (@(posedge io.pclk) disable iff (!io.presetn) // [R19]
    $changed(st_reg.stable) |-> (($past(st_reg.s2) ^ $past(st_reg.s3)) & ($past(st_reg.stable)
    ^ st_reg.stable)) == 7'h00)
    else $error("live pin bit changed while stages disagreed");
endmodule

/* File: hw/gpfm_pin_mux.sv */
// Purpose: Per-pin function select to drive value and enable
// Assumes: Routed clocks pass combinationally from registered selects
// Notes:   Output enable high while the pin is driven
`timescale 1ns/10ps
module gpfm_pin_mux (
  gpfm_io_if.mux io
);
  import gpfm_pkg::*;
  logic rec_clk;
  logic squelch;
  logic rec_sq;
  logic [8:0] oe_c;
  logic [8:0] out_c;

  // Returns {oe, out}
  function automatic logic [1:0] drive(input gpfm_sel_t sel, input logic a3, input logic rec,
                                       input logic a6, input logic a7, input logic od);
    case (sel)
      GPFM_SEL_HIZ:  drive = 2'h0;                       // [R06]
      GPFM_SEL_LOW:  drive = 2'h2;                       // [R01] [R06]
      GPFM_SEL_HIGH: drive = 2'h3;                       // [R01] [R06]
      GPFM_SEL_ALT3: drive = od ? {~a3, 1'b0} : {1'b1, a3}; // [R07] [R12]
      GPFM_SEL_REF:  drive = {1'b1, io.ref_clk};         // [R08]
      GPFM_SEL_REC:  drive = {1'b1, rec};                // [R09] [R13]
      GPFM_SEL_ALT6: drive = {1'b1, a6};
      GPFM_SEL_ALT7: drive = {1'b1, a7};
      default:       drive = 2'h0;
    endcase
  endfunction

  assign rec_clk = io.freq_sel ? io.rec125 : io.rec25;
  // Latched flags keep it low until all clear
  assign squelch = io.squelch_en & (io.alos | io.rlos | io.rlol | ~io.link_lat); // [R17] [R18]
  assign rec_sq  = rec_clk & ~squelch; // [R13]

  always_comb begin
    {oe_c[0], out_c[0]} = drive(io.sel[0], ~io.irq, rec_clk, io.link_up, io.ev1, 1'b0); // [R07] [R09] [R10] [R11]
    {oe_c[1], out_c[1]} = drive(io.sel[1], io.te_clk, rec_sq, io.crs, io.ev2, 1'b0); // [R14] [R15]
    {oe_c[2], out_c[2]} = drive(io.sel[2], ~io.irq, rec_clk, io.link_up, io.ev1, 1'b1);
    {oe_c[3], out_c[3]} = drive(io.sel[3], io.te_clk, rec_sq, io.crs, io.ev2, 1'b0);
    {oe_c[4], out_c[4]} = drive(io.sel[4], ~io.irq, rec_clk, io.link_up, io.ev1, 1'b1);
    for (int i = 5; i < 9; i++) begin
      {oe_c[i], out_c[i]} = drive(io.sel[i], io.te_clk, rec_sq, io.ev1, io.ev2, 1'b0); // [R16]
      oe_c[i] = oe_c[i] & io.narrow; // [R05]
    end
  end

  assign io.pin_out = out_c;
  assign io.pin_oe  = oe_c;

  a_hiz_undriven: assert property (@(posedge io.pclk) disable iff (!io.presetn) // [R06]
    io.sel[3] == GPFM_SEL_HIZ |-> !io.pin_oe[3])
    else $error("pin driven with select 000");
  a_open_drain: assert property (@(posedge io.pclk) disable iff (!io.presetn) // [R07]
    io.sel[4] == GPFM_SEL_ALT3 |-> !io.pin_out[4] && io.pin_oe[4] == io.irq)
    else $error("open-drain interrupt wrong");
  a_squelch_low: assert property (@(posedge io.pclk) disable iff (!io.presetn) // [R17]
    io.sel[1] == GPFM_SEL_REC && io.squelch_en && (io.rlol || !io.link_lat) |-> !io.pin_out[1])
    else $error("recovered clock not squelched");
  a_narrow_gate: assert property (@(posedge io.pclk) disable iff (!io.presetn) // [R05]
    !io.narrow |-> io.pin_oe[8:5] == 4'h0)
    else $error("upper pins driven outside narrow mode");
  a_event_route: assert property (@(posedge io.pclk) disable iff (!io.presetn) // [R16]
    io.narrow && io.sel[6] == GPFM_SEL_ALT6 |-> io.pin_oe[6] && io.pin_out[6] == io.ev1)
    else $error("event one not routed");
endmodule

/* File: tb/gpfm_pin_board.sv */
// Purpose: Board model of the seven two-way pins
// Assumes: Every two-way pin has a pull-up on the board
// Notes:   Opposing drivers resolve to an unknown level
`timescale 1ns/10ps
module gpfm_pin_board (
  // Device side
  input  wire logic [6:0] dev_o,
  input  wire logic [6:0] dev_oe,
  // Bench control of the external driver
  input  wire logic [6:0] ext_en,
  input  wire logic [6:0] ext_val,
  // Resolved pin level
  output logic      [6:0] pin_lvl
);
  // ==========================================
  // Wire resolution
  always_comb begin
    for (int k = 0; k < 7; k++) begin
      if (dev_oe[k] && ext_en[k] && dev_o[k] !== ext_val[k]) begin
        pin_lvl[k] = 1'bx;
      end else if (dev_oe[k]) begin
        pin_lvl[k] = dev_o[k];
      end else if (ext_en[k]) begin
        pin_lvl[k] = ext_val[k];
      end else begin
        pin_lvl[k] = 1'b1;
      end
    end
  end
endmodule

/* File: tb/gpfm_pin_function_mux_tb_top.sv */
// Purpose: Self-checking bench of the pin function block
// Assumes: Routed sources held at static levels
// Notes:   src bits: 7 ref, 6 rec25, 5 te, 4 link, 3 crs, 2 rec125, 1 ev1, 0 ev2
`timescale 1ns/10ps
`include "gpfm_cfg.svh"
module gpfm_pin_function_mux_tb_top;
  import gpfm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, ao_a, oe_a, ao_b, oe_b, irq, narrow;
  logic [6:0]  pin_lvl, pin_o, pin_oe, ext_en, ext_val;
  logic [7:0]  src;
  logic [3:0]  flg;
  logic [3:0]  edges;
  int          fails, n_checks;

  gpfm_pin_function_mux u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .aux_out_a_o(ao_a), .aux_out_a_oe(oe_a), .aux_out_b_o(ao_b),
    .aux_out_b_oe(oe_b), .gen_pin_i(pin_lvl), .gen_pin_o(pin_o), .gen_pin_oe(pin_oe),
    .ref_pll_clk_125(src[7]), .recovered_clk_25(src[6]), .recovered_clk_125(src[2]),
    .link_up(src[4]), .carrier_sense(src[3]), .time_engine_clock_out(src[5]),
    .event_gen_out_1(src[1]), .event_gen_out_2(src[0]), .analog_signal_loss_flag(flg[0]),
    .cdr_signal_loss_flag(flg[1]), .cdr_lock_loss_flag(flg[2]), .link_state_latched(flg[3]),
    .narrow_mii_mode(narrow), .irq(irq));
  gpfm_pin_board u_board (.dev_o(pin_o), .dev_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val),
    .pin_lvl(pin_lvl));

  always #50 pclk = ~pclk;

  // ==========================================
  // Reporting
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ==========================================
  // APB master
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fails++;
      $display("Error pready expected 1 seen %b", pready);
      final_report();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk($sformatf("read %h", a), exp, q);
    chk($sformatf("pslverr %h", a), {31'h0, exp_err}, {31'h0, e});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic set_code(input logic [2:0] c);
    wr(`GPFM_OFF_CFG_A, {17'h0, {5{c}}});
    wr(`GPFM_OFF_CFG_B, {16'h0, edges, {4{c}}});
    tick(1);
  endtask

  // Pin order: aux_a, aux_b, pin1..pin7; irq assumed low
  task automatic check_pins(input logic [2:0] c, input logic ra, input logic rb);
    logic [2:0] v;
    logic [8:0] o9;
    logic [8:0] e9;
    case (c)
      3'h0, 3'h1: v = 3'h0;
      3'h2: v = 3'h7;
      3'h3: v = {src[5], src[5], 1'b1};
      3'h4: v = {3{src[7]}};
      3'h5: v = {rb, rb, ra};
      3'h6: v = {src[1], src[3], src[4]};
      default: v = {src[0], src[0], src[1]};
    endcase
    o9 = {{4{v[2]}}, v[0], v[1], v[0], v[1], v[0]};
    e9 = {9{c != 3'h0}};
    if (c == 3'h3) begin
      e9[4] = 1'b0;
      e9[2] = 1'b0;
    end
    chk($sformatf("pin_oe code %0d", c), {23'h0, e9}, {23'h0, pin_oe, oe_b, oe_a});
    chk($sformatf("pin_o code %0d", c), {23'h0, o9 & e9}, {23'h0, {pin_o, ao_b, ao_a} & e9});
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset();
    rd(`GPFM_OFF_CFG_A, 32'h0, 1'b0);
    rd(`GPFM_OFF_CFG_B, 32'h0, 1'b0);
    rd(`GPFM_OFF_CTRL, 32'h0, 1'b0);
    rd(`GPFM_OFF_IMASK, 32'h0, 1'b0);
    check_pins(3'h0, 1'b0, 1'b0);
    rd(12'h018, 32'h0, 1'b1);
  endtask

  task automatic t_codes();
    for (int p = 0; p < 2; p++) begin
      src <= (p == 0) ? 8'hA5 : 8'h5A;
      for (int c = 0; c < 8; c++) begin
        set_code(3'(c));
        check_pins(3'(c), src[6], src[6]);
      end
    end
  endtask

  task automatic t_recclk();
    src <= 8'hBF;
    set_code(3'h5);
    wr(`GPFM_OFF_CTRL, 32'h1);
    flg <= 4'h9;
    tick(1);
    check_pins(3'h5, 1'b1, 1'b1);
    wr(`GPFM_OFF_CTRL, 32'h3);
    for (int i = 0; i < 4; i++) begin
      flg <= 4'h8 ^ (4'h1 << i);
      tick(2);
      check_pins(3'h5, 1'b1, 1'b0);
    end
    flg <= 4'h8;
    tick(2);
    check_pins(3'h5, 1'b1, 1'b1);
  endtask

  task automatic t_narrow();
    narrow <= 1'b0;
    set_code(3'h0);
    tick(6);
    rd(`GPFM_OFF_STATE, 32'h07, 1'b0);
    set_code(3'h2);
    chk("pin_oe narrow off", 32'h01F, {23'h0, pin_oe, oe_b, oe_a});
    narrow <= 1'b1;
  endtask

  task automatic t_edges();
    set_code(3'h0);
    ext_en <= 7'h7F;
    ext_val <= 7'h00;
    tick(6);
    rd(`GPFM_OFF_STATE, 32'h0, 1'b0);
    wr(`GPFM_OFF_IMASK, 32'h7F);
    edges = 4'h9;
    set_code(3'h0);
    ext_val <= 7'h7F;
    rd(`GPFM_OFF_STATE, 32'h0, 1'b0);
    tick(6);
    chk("irq after rise", 32'h1, {31'h0, irq});
    rd(`GPFM_OFF_STATE, 32'h077F, 1'b0);
    ext_en <= 7'h00;
    wr(`GPFM_OFF_CFG_A, 32'h30C3);
    tick(1);
    chk("irq pins", 32'h15, {26'h0, ao_a, oe_a, pin_o[2], pin_oe[2], pin_o[0], pin_oe[0]});
    wr(`GPFM_OFF_CFG_A, 32'h0);
    tick(8);
    rd(`GPFM_OFF_ISTAT, 32'h07, 1'b0);
    tick(1);
    chk("irq after clear", 32'h0, {31'h0, irq});
    rd(`GPFM_OFF_STATE, 32'h057F, 1'b0);
    rd(`GPFM_OFF_STATE, 32'h007F, 1'b0);
    wr(`GPFM_OFF_IMASK, 32'h0);
    ext_en <= 7'h7F;
    ext_val <= 7'h00;
    tick(7);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(`GPFM_OFF_ISTAT, 32'h78, 1'b0);
    rd(`GPFM_OFF_STATE, 32'h7800, 1'b0);
    edges = 4'h3;
    set_code(3'h0);
    ext_val <= 7'h7F;
    tick(7);
    rd(`GPFM_OFF_STATE, 32'h077F, 1'b0);
    ext_val <= 7'h00;
    tick(7);
    rd(`GPFM_OFF_STATE, 32'h0700, 1'b0);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    src = 8'h00;
    flg = 4'h8;
    narrow = 1'b1;
    ext_en = 7'h00;
    ext_val = 7'h00;
    edges = 4'h0;
    fails = 0;
    n_checks = 0;
    tick(12);
    presetn <= 1'b1;
    tick(1);
    t_reset();
    t_codes();
    t_recclk();
    t_narrow();
    t_edges();
    final_report();
  end
endmodule
